// [rca_defines.vh]
/*
  constants for the record check and answerback block: register offsets,
  field positions, reset values and line character codes.
  assumes 7-bit characters, bit 0..6 = 1,2,4,8,a,b,c positions.
*/
`ifndef RCA_DEFINES_VH
`define RCA_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define RCA_OFF_CTRL    8'h00
`define RCA_OFF_CONFIG  8'h04
`define RCA_OFF_STATUS  8'h08
`define RCA_OFF_TXDATA  8'h0c
`define RCA_OFF_RXDATA  8'h10
`define RCA_OFF_LRC     8'h14

// ****************************************
// control register bits (write pulses)
// ****************************************
`define RCA_CTRL_GO_TX    0
`define RCA_CTRL_GO_RX    1
`define RCA_CTRL_EOB      2
`define RCA_CTRL_RESTART  3
`define RCA_CTRL_EOT      4

// ****************************************
// config and status bits
// ****************************************
`define RCA_CFG_BID       0
`define RCA_CFG_RESET     32'h0000_0000
`define RCA_ST_ERR_TRIG   8
`define RCA_ST_STORED     9
`define RCA_ST_ATTN       10
`define RCA_ST_LOCK       11
`define RCA_ST_RX_VALID   12
`define RCA_ST_TX_PEND    13

// ****************************************
// character codes
// ****************************************
`define RCA_CH_BID_ST   7'h02
`define RCA_CH_ENTER    7'h01
`define RCA_CH_BUFPRT   7'h04
`define RCA_CH_PAPER    7'h49
`define RCA_CH_LOCAL    7'h08
`define RCA_CH_INSERT   7'h20
`define RCA_CH_STORED   7'h10
`define RCA_CH_EOB      7'h30
`define RCA_CH_EOT      7'h70
`define RCA_CH_YES      7'h51
`define RCA_CH_NO       7'h52
`define RCA_CH_QUAL_POS 7'h51
`define RCA_CH_QUAL_NEG 7'h52
`define RCA_CH_HYPHEN   7'h40

`endif

// [rca_lrc.v]
/*
  longitudinal check accumulator and vertical parity test.
  assumes the caller pulses acc_en once per character and clr on mode changes other than into M_TX_LRC, M_RX_LRC or M_TX_CHK.
*/
`timescale 1ns/1ps
module rca_lrc
(
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       clr,
  input  wire       acc_en,
  input  wire [6:0] data,
  output wire [6:0] lrc,
  output wire       par_ok
);
  reg [6:0] lrc_reg;

  // ****************************************
  // per-position odd/even count
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lrc_reg <= 7'h00;
    else if (clr)
      lrc_reg <= 7'h00;
    else if (acc_en)
      lrc_reg <= lrc_reg ^ data;
  end

  assign lrc    = lrc_reg;
  assign par_ok = ^data;
endmodule

// [rca_top.v]
/*
  record check and answerback selection: vertical parity, longitudinal check,
  end-of-block exchange on both ends, answerback choice when addressed, and an
  ahb-lite register slave. assumes a same-clock serializer on the tx/rx
  character ports and asynchronous terminal status pins.
*/
// Summary of operation
// - addressed while not ready: qualified not-ready reply, stored errors kept
// - bid pending: answerback starts with the 2 bit character
// - enter status in communicate: answerback starts with the 1 bit
// - buffer print in communicate: answerback starts with the 4 bit
// - paper out, local or insert down: negative reply, attention, alarm
// - paper out, no inhibit, no bid: first character is 1, 8, c bits
// - not communicate: first character is the 8 bit alone
// - paper in, insert down, no inhibit, no bid: first character is @
// - received character with even ones prints hyphen, sets error trigger
// - seven-bit running odd/even count per bit position on both ends
// - longitudinal compare only during the end-of-block exchange
// - sender sends b, then check character, then waits for reply
// - reply y resumes text; other reply: hyphen, alarm, locked
// - lock holds until restart (text) or eot (send end, control receive)
// - received b: next character is the check, parity not tested
// - check character mismatch sets error trigger and prints hyphen
// - receiver answers n on error else y, returns to receive text
// - stored error character goes first, qualifier goes second
// - stored error latches clear after the qualifier, the second status character, leaves
`timescale 1ns/1ps
`include "rca_defines.vh"
module rca_top
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        paper_present,
  input  wire        insert_down,
  input  wire        communicate,
  input  wire        enter_status,
  input  wire        buffer_print,
  input  wire        status_inhibit,
  input  wire        ready_rx,
  input  wire        addressed,
  input  wire        rx_strobe,
  input  wire [6:0]  rx_char,
  input  wire        rx_stop_ok,
  output wire        tx_valid,
  output wire [6:0]  tx_char,
  input  wire        tx_ready,
  output wire        print_valid,
  output wire [6:0]  print_char,
  output wire        alarm,
  output wire        attention,
  output wire        keyboard_lock
);
  // ****************************************
  // modes
  // ****************************************
  localparam [7:0] M_CTRL_RX = 8'h01;
  localparam [7:0] M_TX_TEXT = 8'h02;
  localparam [7:0] M_TX_LRC  = 8'h04;
  localparam [7:0] M_RX_CHK  = 8'h08;
  localparam [7:0] M_TX_LOCK = 8'h10;
  localparam [7:0] M_RX_TEXT = 8'h20;
  localparam [7:0] M_RX_LRC  = 8'h40;
  localparam [7:0] M_TX_CHK  = 8'h80;

  reg  [7:0]  mode_reg;
  reg  [6:0]  s1_reg;
  reg  [6:0]  s2_reg;
  reg  [6:0]  s3_reg;
  reg  [6:0]  pin_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg  [31:0] rdata_reg;
  reg         bid_reg;
  reg  [6:0]  txd_reg;
  reg         txd_pend_reg;
  reg  [6:0]  rxd_reg;
  reg         rxd_valid_reg;
  reg         tx_valid_reg;
  reg  [6:0]  tx_char_reg;
  reg         prt_reg;
  reg         alarm_reg;
  reg         attn_reg;
  reg         err_trig_reg;
  reg         stored_reg;
  reg  [6:0]  qual_reg;
  reg         qual_pend_reg;
  reg         clr_stored_reg;
  wire [6:0]  lrc;
  wire        par_ok;
  wire        lrc_acc;
  wire        lrc_clr;
  wire [6:0]  lrc_data;

  wire p_paper  = pin_reg[0];
  wire p_insert = pin_reg[1];
  wire p_comm   = pin_reg[2];
  wire p_enter  = pin_reg[3];
  wire p_bufprt = pin_reg[4];
  wire p_inhib  = pin_reg[5];
  wire p_ready  = pin_reg[6];

  // ****************************************
  // status pin synchronisers
  // ****************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg  <= 7'h00;
      s2_reg  <= 7'h00;
      s3_reg  <= 7'h00;
      pin_reg <= 7'h00;
    end
    else
    begin
      s1_reg  <= {ready_rx, status_inhibit, buffer_print, enter_status, communicate,
                  insert_down, paper_present};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= (s2_reg == s3_reg) ? s3_reg : pin_reg;
    end
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  wire        acc     = hsel && hready && htrans[1];
  wire        wr_now  = wr_pend_reg;
  wire [31:0] status  = {18'h0, txd_pend_reg, rxd_valid_reg, (mode_reg == M_TX_LOCK),
                         attn_reg, stored_reg, err_trig_reg, mode_reg};
  wire        ctl_wr  = wr_now && (wr_addr_reg == `RCA_OFF_CTRL);
  wire        k_go_tx = ctl_wr && hwdata[`RCA_CTRL_GO_TX];
  wire        k_go_rx = ctl_wr && hwdata[`RCA_CTRL_GO_RX];
  wire        k_eob   = ctl_wr && hwdata[`RCA_CTRL_EOB];
  wire        k_rst   = ctl_wr && hwdata[`RCA_CTRL_RESTART];
  wire        k_eot   = ctl_wr && hwdata[`RCA_CTRL_EOT];
  wire        rx_rd   = acc && !hwrite && (haddr == `RCA_OFF_RXDATA);

  function [31:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `RCA_OFF_CONFIG: rd_mux = {31'h0, bid_reg};
        `RCA_OFF_STATUS: rd_mux = status;
        `RCA_OFF_TXDATA: rd_mux = {25'h0, txd_reg};
        `RCA_OFF_RXDATA: rd_mux = {25'h0, rxd_reg};
        `RCA_OFF_LRC:    rd_mux = {25'h0, lrc};
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
      bid_reg     <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= acc && hwrite;
      if (acc)
        wr_addr_reg <= haddr;
      if (acc && !hwrite)
        rdata_reg <= rd_mux(haddr);
      if (wr_now && (wr_addr_reg == `RCA_OFF_CONFIG))
        bid_reg <= hwdata[`RCA_CFG_BID];
    end
  end

  assign hrdata    = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************
  // answerback selection
  // ****************************************
  wire op_err = !p_paper || !p_comm || p_insert;
  wire in_ctrl = (mode_reg == M_CTRL_RX);
  wire ab_go  = addressed && in_ctrl && !tx_valid_reg && !qual_pend_reg;

  // first character by priority; zero means qualifier alone
  function [6:0] first_char;
    input paper, comm, ins, inhib, bid, enter, bufprt, ready, stored;
    begin
      if (!comm)
        first_char = `RCA_CH_LOCAL;
      else if (!paper && !inhib && !bid)
        first_char = `RCA_CH_PAPER;
      else if (paper && ins && !inhib && !bid)
        first_char = `RCA_CH_INSERT;
      else if (bid)
        first_char = `RCA_CH_BID_ST;
      else if (enter)
        first_char = `RCA_CH_ENTER;
      else if (bufprt)
        first_char = `RCA_CH_BUFPRT;
      else if (!ready)
        first_char = 7'h00;
      else if (stored)
        first_char = `RCA_CH_STORED;
      else
        first_char = 7'h00;
    end
  endfunction

  wire [6:0] ab_first = first_char(p_paper, p_comm, p_insert, p_inhib, bid_reg, p_enter,
                                   p_bufprt, p_ready, stored_reg);
  wire [6:0] ab_qual  = op_err ? `RCA_CH_QUAL_NEG : `RCA_CH_QUAL_POS;
  // stored errors survive a not-ready or operational reply
  wire ab_clears = p_ready && !op_err && stored_reg && (ab_first == `RCA_CH_STORED);

  // ****************************************
  // mode machine and character flow
  // ****************************************
  wire tx_free  = !tx_valid_reg || tx_ready;
  wire rx_bad   = !par_ok || !rx_stop_ok;
  wire is_eob   = (rx_char == `RCA_CH_EOB);
  wire rx_text  = rx_strobe && (mode_reg == M_RX_TEXT);
  wire rx_check = rx_strobe && (mode_reg == M_RX_LRC);
  wire lrc_miss = rx_check && ((lrc ^ rx_char) != 7'h00);
  wire par_err  = rx_text && !is_eob && rx_bad;
  wire tx_text  = (mode_reg == M_TX_TEXT) && tx_free && !k_eob && txd_pend_reg;
  wire tx_eob   = (mode_reg == M_TX_TEXT) && tx_free && k_eob;
  wire tx_ans   = (mode_reg == M_TX_CHK) && tx_free;
  reg  [7:0] mode_next;

  assign lrc_acc  = rx_text || tx_text || tx_eob;
  // gated by rx_text so a stray line strobe in a send mode cannot spoil the count
  assign lrc_data = rx_text ? rx_char : (tx_eob ? `RCA_CH_EOB : txd_reg);
  assign lrc_clr  = (mode_next != mode_reg) && (mode_next != M_TX_LRC)
                    && (mode_next != M_RX_LRC) && (mode_next != M_TX_CHK);

  always @*
  begin
    mode_next = mode_reg;
    case (mode_reg)
      M_CTRL_RX:
        if (k_go_tx)
          mode_next = M_TX_TEXT;
        else if (k_go_rx)
          mode_next = M_RX_TEXT;
      M_TX_TEXT:
        if (tx_eob)
          mode_next = M_TX_LRC;
      M_TX_LRC:
        if (tx_free)
          mode_next = M_RX_CHK;
      M_RX_CHK:
        if (rx_strobe)
          mode_next = (rx_char == `RCA_CH_YES) ? M_TX_TEXT : M_TX_LOCK;
      M_TX_LOCK:
        if (k_rst)
          mode_next = M_TX_TEXT;
        else if (k_eot && tx_free)
          mode_next = M_CTRL_RX;
      M_RX_TEXT:
        if (rx_strobe && is_eob)
          mode_next = M_RX_LRC;
      M_RX_LRC:
        if (rx_strobe)
          mode_next = M_TX_CHK;
      M_TX_CHK:
        if (tx_ans)
          mode_next = M_RX_TEXT;
      default:
        mode_next = M_CTRL_RX;
    endcase
  end

  rca_lrc u_lrc
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (lrc_clr),
    .acc_en  (lrc_acc),
    .data    (lrc_data),
    .lrc     (lrc),
    .par_ok  (par_ok)
  );

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_reg       <= M_CTRL_RX;
      tx_valid_reg   <= 1'b0;
      tx_char_reg    <= 7'h00;
      txd_reg        <= 7'h00;
      txd_pend_reg   <= 1'b0;
      rxd_reg        <= 7'h00;
      rxd_valid_reg  <= 1'b0;
      prt_reg        <= 1'b0;
      alarm_reg      <= 1'b0;
      attn_reg       <= 1'b0;
      err_trig_reg   <= 1'b0;
      stored_reg     <= 1'b0;
      qual_reg       <= 7'h00;
      qual_pend_reg  <= 1'b0;
      clr_stored_reg <= 1'b0;
    end
    else
    begin
      mode_reg  <= mode_next;
      prt_reg   <= par_err || lrc_miss || ((mode_reg == M_RX_CHK) && rx_strobe
                   && (rx_char != `RCA_CH_YES));
      alarm_reg <= ((mode_reg == M_RX_CHK) && rx_strobe && (rx_char != `RCA_CH_YES))
                   || (ab_go && op_err);
      if (tx_valid_reg && tx_ready)
        tx_valid_reg <= 1'b0;
      if (wr_now && (wr_addr_reg == `RCA_OFF_TXDATA) && !txd_pend_reg)
      begin
        txd_reg      <= hwdata[6:0];
        txd_pend_reg <= 1'b1;
      end
      else if (tx_text)
        txd_pend_reg <= 1'b0;
      if (rx_text)
      begin
        rxd_reg       <= rx_char;
        rxd_valid_reg <= 1'b1;
      end
      else if (rx_rd)
        rxd_valid_reg <= 1'b0;
      // an error arriving with the answer wins over the clear
      if (par_err || lrc_miss)
        err_trig_reg <= 1'b1;
      else if (tx_ans)
        err_trig_reg <= 1'b0;
      if (par_err)
        stored_reg <= 1'b1;
      else if (clr_stored_reg && !tx_valid_reg)
        stored_reg <= 1'b0;
      if (clr_stored_reg && !tx_valid_reg)
        clr_stored_reg <= 1'b0;
      if (ab_go && op_err)
        attn_reg <= 1'b1;
      else if (!op_err)
        attn_reg <= 1'b0;
      // one transmit slot, so at most one launch per cycle
      if (tx_text)
      begin
        tx_valid_reg <= 1'b1;
        tx_char_reg  <= txd_reg;
      end
      else if (tx_eob)
      begin
        tx_valid_reg <= 1'b1;
        tx_char_reg  <= `RCA_CH_EOB;
      end
      else if ((mode_reg == M_TX_LRC) && tx_free)
      begin
        tx_valid_reg <= 1'b1;
        tx_char_reg  <= lrc;
      end
      else if (tx_ans)
      begin
        tx_valid_reg <= 1'b1;
        tx_char_reg  <= err_trig_reg ? `RCA_CH_NO : `RCA_CH_YES;
      end
      else if ((mode_reg == M_TX_LOCK) && !k_rst && k_eot && tx_free)
      begin
        tx_valid_reg <= 1'b1;
        tx_char_reg  <= `RCA_CH_EOT;
      end
      else if (ab_go)
      begin
        tx_valid_reg <= 1'b1;
        if (ab_first != 7'h00)
        begin
          tx_char_reg   <= ab_first;
          qual_reg      <= ab_qual;
          qual_pend_reg <= 1'b1;
          clr_stored_reg <= ab_clears;
        end
        else
          tx_char_reg <= ab_qual;
      end
      else if (qual_pend_reg && tx_free)
      begin
        tx_valid_reg  <= 1'b1;
        tx_char_reg   <= qual_reg;
        qual_pend_reg <= 1'b0;
      end
    end
  end

  assign tx_valid      = tx_valid_reg;
  assign tx_char       = tx_char_reg;
  assign print_valid   = prt_reg;
  assign print_char    = `RCA_CH_HYPHEN;
  assign alarm         = alarm_reg;
  assign attention     = attn_reg;
  assign keyboard_lock = (mode_reg == M_TX_LOCK);
endmodule

// [rca_monitor.sv]
/*
  port checks for the record check and answerback block.
  assumes one clock hclk and an asynchronous active-low hresetn.
*/
`timescale 1ns/1ps
module rca_monitor
(
  input wire       hclk,
  input wire       hresetn,
  input wire       hsel,
  input wire       hready,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       addressed,
  input wire       rx_strobe,
  input wire       tx_valid,
  input wire [6:0] tx_char,
  input wire       tx_ready,
  input wire       print_valid,
  input wire [6:0] print_char,
  input wire       alarm,
  input wire       attention,
  input wire       keyboard_lock
);
  // ****************
  // helper and checks
  // ****************
  reg wr_q;

  // a control write lands one edge after its address phase
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_q <= 1'b0;
    else
      wr_q <= hsel && hready && htrans[1] && hwrite;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_lock_rise;
    !keyboard_lock ##1 keyboard_lock;
  endsequence

  AST_TX_HOLD: assert property (s_stall |=> tx_valid && $stable(tx_char))
    else $error("line character dropped or changed before taken");
  AST_PRINT_PULSE: assert property (print_valid
    |-> print_char == 7'h40 ##1 !print_valid)
    else $error("hyphen print not a single pulse");
  AST_PRINT_CAUSE: assert property (print_valid |-> $past(rx_strobe))
    else $error("hyphen printed without a received character");
  AST_LOCK_ENTRY: assert property (s_lock_rise
    |-> alarm && print_valid && $past(rx_strobe))
    else $error("lock entered without hyphen and alarm on a reply");
  AST_LOCK_STAY: assert property (keyboard_lock && !wr_q
    && !(hsel && htrans[1] && hwrite) |=> keyboard_lock)
    else $error("lock left without a keyed restart or end");
  AST_ALARM_PULSE: assert property (alarm |=> !alarm)
    else $error("alarm longer than one cycle");
  AST_ALARM_CAUSE: assert property (alarm |-> $past(rx_strobe) || $past(addressed)
    || $past(addressed, 2))
    else $error("alarm without a reply or an address");
  AST_ATTN_CAUSE: assert property ($rose(attention) |-> $past(addressed)
    || $past(addressed, 2))
    else $error("attention raised while not addressed");
  AST_ANSWER_START: assert property (addressed && !tx_valid |=> tx_valid)
    else $error("no answerback after address");
endmodule

bind rca_top rca_monitor u_mon
(
  .hclk, .hresetn, .hsel, .hready, .htrans, .hwrite, .addressed, .rx_strobe, .tx_valid,
  .tx_char, .tx_ready, .print_valid, .print_char, .alarm, .attention, .keyboard_lock
);

// [rca_far.sv]
/*
  far-side line partner: takes characters the block sends and sends text,
  replies and check characters back. assumes same-clock character ports.
*/
`timescale 1ns/1ps
module rca_far
(
  input  wire        hclk,
  input  wire        tx_valid,
  input  wire [6:0]  tx_char,
  input  wire        slow,
  output logic       tx_ready,
  output logic       rx_strobe,
  output logic [6:0] rx_char,
  output logic       rx_stop_ok
);
  // ****************
  // line partner
  // ****************
  logic [6:0] got[$];
  logic [6:0] lrc = 7'h00;

  initial
  begin
    tx_ready = 1'b0;
    rx_strobe = 1'b0;
    rx_char = 7'h7f;
    rx_stop_ok = 1'b0;
  end

  // a slow far end takes at most every other character slot
  always @(posedge hclk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_char);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  task automatic send(input logic [6:0] c);
    @(posedge hclk);
    rx_char <= c;
    rx_strobe <= 1'b1;
    rx_stop_ok <= 1'b1;
    lrc = lrc ^ c;
    @(posedge hclk);
    rx_strobe <= 1'b0;
    // idle line shows the inverse so a stale value is never read as data
    rx_char <= ~c;
    rx_stop_ok <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic send_check(input logic [6:0] flip);
    send(lrc ^ flip);
    lrc = 7'h00;
  endtask
endmodule

// [tb_record_check_answerback.sv]
/*
  self-checking bench for the record check and answerback block.
  assumes rca_top, the partner rca_far and the bound port monitor.
*/
`timescale 1ns/1ps
module tb_record_check_answerback;
  // ****************
  // signals
  // ****************
  typedef struct packed {
    logic [6:0] f;
    logic [1:0] n;
    logic [6:0] c0;
    logic [6:0] c1;
    logic       op;
  } rca_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        addressed = 1'b0;
  logic        slow = 1'b0;
  logic        communicate = 1'b1;
  logic        paper_present = 1'b1;
  logic        insert_down = 1'b0;
  logic        enter_status = 1'b0;
  logic        buffer_print = 1'b0;
  logic        ready_rx = 1'b1;
  logic        status_inhibit = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire  [6:0]  tx_char, rx_char, print_char;
  wire         hreadyout, hresp, tx_valid, tx_ready, print_valid, alarm;
  wire         attention, keyboard_lock, rx_strobe, rx_stop_ok;
  int          fail_count = 0, check_count = 0, alarm_n = 0, print_n = 0, a0, p0;
  rca_row_t    r;
  // flags: communicate, paper, insert, enter, buffer print, ready, bid
  rca_row_t    rows [8] = '{'{7'h22, 2'h2, 7'h08, 7'h52, 1'b1},
    '{7'h42, 2'h2, 7'h49, 7'h52, 1'b1}, '{7'h72, 2'h2, 7'h20, 7'h52, 1'b1},
    '{7'h63, 2'h2, 7'h02, 7'h51, 1'b0}, '{7'h6a, 2'h2, 7'h01, 7'h51, 1'b0},
    '{7'h66, 2'h2, 7'h04, 7'h51, 1'b0}, '{7'h60, 2'h1, 7'h51, 7'h00, 1'b0},
    '{7'h62, 2'h1, 7'h51, 7'h00, 1'b0}};

  rca_top u_dut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .paper_present, .insert_down,
    .communicate, .enter_status, .buffer_print, .status_inhibit, .ready_rx,
    .addressed, .rx_strobe, .rx_char, .rx_stop_ok, .tx_valid, .tx_char, .tx_ready,
    .print_valid, .print_char, .alarm, .attention, .keyboard_lock
  );
  rca_far u_far
  (
    .hclk, .tx_valid, .tx_char, .slow, .tx_ready, .rx_strobe, .rx_char, .rx_stop_ok
  );

  always #4 hclk = ~hclk;

  always @(posedge hclk)
  begin
    if (alarm === 1'b1)
      alarm_n <= alarm_n + 1;
    if (print_valid === 1'b1)
      print_n <= print_n + 1;
  end

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] v);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v & m, e);
  endtask

  task automatic wait_tx(input int n);
    int k;
    k = 0;
    while (u_far.got.size() < n && k < 60)
    begin
      @(posedge hclk);
      k++;
    end
    repeat (4) @(posedge hclk);
    chk(u_far.got.size(), n);
  endtask

  task automatic rx_blk(input logic [6:0] a, input logic [6:0] flip, input logic npre,
                        input logic [6:0] rep);
    u_far.lrc = 7'h00;
    u_far.got.delete();
    p0 = print_n;
    u_far.send(a);
    u_far.send(7'h07);
    u_far.send(7'h30);
    chk(print_n - p0, npre);
    rdm(8'h08, 32'h100, {23'h0, npre, 8'h00});
    u_far.send_check(flip);
    wait_tx(1);
    chk(print_n - p0, npre + (flip != 7'h00));
    chk(u_far.got[0], rep);
    rdm(8'h08, 32'h1ff, 32'h20);
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****************
  // sequence
  // ****************
  // the whole run needs a few hundred cycles; this limit is 37500 cycles
  initial
  begin
    #300000;
    fail_count++;
    end_sim;
  end

  initial
  begin
    repeat (8) @(posedge hclk);
    chk({hreadyout, hresp, print_char}, 9'h140);
    hresetn <= 1'b1;
    rdm(8'h08, 32'h1ff, 32'h1);
    rdm(8'h04, 32'hffffffff, 32'h0);
    rdm(8'h18, 32'hffffffff, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      r = rows[i];
      wr(8'h04, {31'h0, r.f[0]});
      {communicate, paper_present, insert_down, enter_status, buffer_print, ready_rx} <= r.f[6:1];
      slow <= i[0];
      // status pins need up to four edges through the synchronisers
      repeat (6) @(posedge hclk);
      u_far.got.delete();
      a0 = alarm_n;
      addressed <= 1'b1; // addressed once, only from control receive
      @(posedge hclk);
      addressed <= 1'b0;
      wait_tx(r.n);
      chk(u_far.got[0], r.c0);
      if (r.n == 2'h2)
        chk(u_far.got[1], r.c1);
      chk(attention, r.op);
      chk(alarm_n - a0, r.op);
      $display("answerback case %0d done", i);
    end
    // paper out with status suppress active: no sense character, negative qualifier only
    status_inhibit <= 1'b1;
    paper_present <= 1'b0;
    repeat (6) @(posedge hclk);
    u_far.got.delete();
    addressed <= 1'b1;
    @(posedge hclk);
    addressed <= 1'b0;
    wait_tx(1);
    chk(u_far.got[0], 7'h52);
    chk(attention, 1'b1);
    status_inhibit <= 1'b0;
    paper_present <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(attention, 1'b0);
    $display("inhibit case done");
    slow <= 1'b1;
    wr(8'h00, 32'h1);
    u_far.got.delete();
    wr(8'h0c, 32'h1);
    wait_tx(1);
    wr(8'h00, 32'h4);
    wait_tx(3);
    chk(u_far.got[1], 7'h30);
    chk(u_far.got[2], 7'h31);
    rdm(8'h08, 32'hff, 32'h8);
    u_far.send(7'h51);
    rdm(8'h08, 32'hff, 32'h2);
    u_far.got.delete();
    wr(8'h00, 32'h4);
    wait_tx(2);
    chk(u_far.got[1], 7'h30);
    p0 = print_n;
    a0 = alarm_n;
    u_far.send(7'h45);
    // the pulse counters settle one edge after the task returns
    @(posedge hclk);
    chk(print_n - p0, 1);
    chk(alarm_n - a0, 1);
    repeat (8) @(posedge hclk);
    chk(keyboard_lock, 1'b1);
    wr(8'h00, 32'h8);
    rdm(8'h08, 32'hff, 32'h2);
    chk(keyboard_lock, 1'b0);
    u_far.got.delete();
    wr(8'h00, 32'h4);
    wait_tx(2);
    u_far.send(7'h52);
    wr(8'h00, 32'h10);
    wait_tx(3);
    chk(u_far.got[2], 7'h70);
    rdm(8'h08, 32'hff, 32'h1);
    $display("send side test done");
    slow <= 1'b0;
    wr(8'h00, 32'h2);
    rx_blk(7'h01, 7'h00, 1'b0, 7'h51);
    rx_blk(7'h03, 7'h00, 1'b1, 7'h52);
    rx_blk(7'h01, 7'h01, 1'b0, 7'h52);
    $display("receive side test done");
    end_sim;
  end
endmodule
